// ==== src/evau_arith_unit.sv ====
// arithmetic datapath shared by the three program execution engines
`timescale 1ns/1ps
`include "evau_params.svh"
module evau_arith_unit (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  evau_pkg::evau_cmd_t         cmd,
  output evau_pkg::evau_rsp_t         rsp,
  output logic [`EVAU_DATA_W-1:0]     global_var,
  output logic [3*`EVAU_DATA_W-1:0]   local_a_flat,
  output logic [3*`EVAU_DATA_W-1:0]   local_b_flat
);
  // registered part of this module: the shared variable and the answer
  typedef struct packed {
    logic [`EVAU_DATA_W-1:0] var_c;
    evau_pkg::evau_rsp_t     rsp;
  } evau_state_t;

  evau_state_t                state_reg;
  evau_state_t                state_next;

  // private variable pairs, one per engine
  evau_pkg::evau_local_t      loc [`EVAU_NUM_ENG];
  logic [`EVAU_NUM_ENG-1:0]   eng_hit;
  logic [`EVAU_NUM_ENG-1:0]   loc_wr;

  // command decode
  logic                       cmd_live;
  logic                       eng_ok;
  logic                       tgt_ok;
  logic                       refused;
  logic                       wr_en;
  logic                       wr_c;
  logic                       wr_local;

  // operands of the addressed engine
  evau_pkg::evau_local_t      eng_vars;
  logic [`EVAU_DATA_W-1:0]    op1;
  logic [`EVAU_DATA_W-1:0]    op2;
  logic [`EVAU_DATA_W-1:0]    tgt_val;

  // eight-bit results, so that carry and borrow fall away
  logic [`EVAU_DATA_W-1:0]    sum_res;
  logic [`EVAU_DATA_W-1:0]    subi_res;
  logic [`EVAU_DATA_W-1:0]    subv_res;
  logic [`EVAU_DATA_W-1:0]    res;

  // one private A/B pair per engine
  for (genvar e = 0; e < `EVAU_NUM_ENG; e++) begin : g_eng
    evau_local_vars u_vars (
      .core_clk (core_clk),
      .rst      (rst),
      .wr_en    (loc_wr[e]),
      .wr_sel   (cmd.target),
      .wr_data  (res),
      .vars     (loc[e])
    );

    // engine e sits at bits 8e+7 down to 8e of the flat outputs
    assign local_a_flat[e*`EVAU_DATA_W +: `EVAU_DATA_W] = loc[e].var_a;
    assign local_b_flat[e*`EVAU_DATA_W +: `EVAU_DATA_W] = loc[e].var_b;
  end

  // decode, operand selection and arithmetic in one combinational pass
  always_comb begin
    // accepted only when valid and not the empty code
    cmd_live = cmd.valid && (cmd.op != evau_pkg::EVAU_OP_NONE);
    // engine code 3 names no engine and is refused
    eng_ok   = cmd.engine < `EVAU_ENG_W'(`EVAU_NUM_ENG);
    for (int i = 0; i < `EVAU_NUM_ENG; i++) begin
      eng_hit[i] = (cmd.engine == `EVAU_ENG_W'(i));
    end

    // every operation writes A, B or C only, never the mapped code
    case (cmd.op)
      evau_pkg::EVAU_OP_ADD_VARS: begin
        tgt_ok = eng_ok && (cmd.target != `EVAU_SEL_MAP);
      end
      evau_pkg::EVAU_OP_SUB_IMM: begin
        tgt_ok = eng_ok && (cmd.target != `EVAU_SEL_MAP);
      end
      evau_pkg::EVAU_OP_SUB_VARS: begin
        tgt_ok = eng_ok && (cmd.target != `EVAU_SEL_MAP);
      end
      default: begin
        tgt_ok = 1'h0;
      end
    endcase
    refused = cmd_live && !tgt_ok;

    // variables of the addressed engine; a refused engine code reads engine 0
    case (cmd.engine)
      2'h0: begin
        eng_vars = loc[0];
      end
      2'h1: begin
        eng_vars = loc[1];
      end
      2'h2: begin
        eng_vars = loc[2];
      end
      default: begin
        eng_vars = loc[0];
      end
    endcase

    // first source operand
    case (cmd.src1)
      `EVAU_SEL_A: begin
        op1 = eng_vars.var_a;
      end
      `EVAU_SEL_B: begin
        op1 = eng_vars.var_b;
      end
      `EVAU_SEL_C: begin
        op1 = state_reg.var_c;
      end
      default: begin
        op1 = cmd.mapped;
      end
    endcase

    // second source operand
    case (cmd.src2)
      `EVAU_SEL_A: begin
        op2 = eng_vars.var_a;
      end
      `EVAU_SEL_B: begin
        op2 = eng_vars.var_b;
      end
      `EVAU_SEL_C: begin
        op2 = state_reg.var_c;
      end
      default: begin
        op2 = cmd.mapped;
      end
    endcase

    // current value of the target, for the in-place subtract
    case (cmd.target)
      `EVAU_SEL_A: begin
        tgt_val = eng_vars.var_a;
      end
      `EVAU_SEL_B: begin
        tgt_val = eng_vars.var_b;
      end
      `EVAU_SEL_C: begin
        tgt_val = state_reg.var_c;
      end
      default: begin
        // code 3 is refused as a target, so this value is never written
        tgt_val = '0;
      end
    endcase

    // eight-bit arithmetic: a carry or borrow out of bit 7 is lost
    sum_res  = op1 + op2;
    subi_res = tgt_val - cmd.imm;
    subv_res = op1 - op2;

    // the operation picks which result is written
    case (cmd.op)
      evau_pkg::EVAU_OP_ADD_VARS: begin
        res = sum_res;
      end
      evau_pkg::EVAU_OP_SUB_IMM: begin
        res = subi_res;
      end
      evau_pkg::EVAU_OP_SUB_VARS: begin
        res = subv_res;
      end
      default: begin
        res = tgt_val;
      end
    endcase

    // one write strobe per destination
    wr_en    = cmd_live && tgt_ok;
    wr_c     = wr_en && (cmd.target == `EVAU_SEL_C);
    wr_local = wr_en && (cmd.target != `EVAU_SEL_C);
    for (int i = 0; i < `EVAU_NUM_ENG; i++) begin
      loc_wr[i] = wr_local && eng_hit[i];
    end

    // only C lives here; A and B live in the engine modules
    state_next = state_reg;
    if (wr_c) begin
      state_next.var_c = res;
    end
    // done and refusal stand for one cycle only
    state_next.rsp.done       = cmd_live;
    state_next.rsp.bad_target = refused;
    // the result holds until the next accepted write
    if (wr_en) begin
      state_next.rsp.result = res;
    end
  end

  // rst clears C and the answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg.var_c <= `EVAU_VAR_RST;
      state_reg.rsp   <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output comes straight from a register
  assign rsp        = state_reg.rsp;
  assign global_var = state_reg.var_c;
endmodule : evau_arith_unit

// ==== inc/evau_params.svh ====
// constants for the engine variable arithmetic unit
`ifndef EVAU_PARAMS_SVH
`define EVAU_PARAMS_SVH
`define EVAU_DATA_W      8
`define EVAU_NUM_ENG     3
`define EVAU_SEL_W       2
`define EVAU_ENG_W       2
`define EVAU_SEL_A       2'h0
`define EVAU_SEL_B       2'h1
`define EVAU_SEL_C       2'h2
`define EVAU_SEL_MAP     2'h3
`define EVAU_VAR_RST     8'h00
`endif

// ==== inc/evau_pkg.sv ====
// types for the engine variable arithmetic unit
`include "evau_params.svh"
package evau_pkg;
  typedef enum logic [1:0] {
    EVAU_OP_NONE,
    EVAU_OP_ADD_VARS,
    EVAU_OP_SUB_IMM,
    EVAU_OP_SUB_VARS
  } evau_op_t;

  typedef struct packed {
    logic                       valid;
    evau_op_t                   op;
    logic [`EVAU_ENG_W-1:0]     engine;
    logic [`EVAU_SEL_W-1:0]     target;
    logic [`EVAU_SEL_W-1:0]     src1;
    logic [`EVAU_SEL_W-1:0]     src2;
    logic [`EVAU_DATA_W-1:0]    imm;
    logic [`EVAU_DATA_W-1:0]    mapped;
  } evau_cmd_t;

  typedef struct packed {
    logic                       done;
    logic                       bad_target;
    logic [`EVAU_DATA_W-1:0]    result;
  } evau_rsp_t;

  typedef struct packed {
    logic [`EVAU_DATA_W-1:0]    var_a;
    logic [`EVAU_DATA_W-1:0]    var_b;
  } evau_local_t;
endpackage : evau_pkg

// ==== src/evau_local_vars.sv ====
// private variables A and B of one execution engine
`timescale 1ns/1ps
`include "evau_params.svh"
module evau_local_vars (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    wr_en,
  input  wire logic [`EVAU_SEL_W-1:0]  wr_sel,
  input  wire logic [`EVAU_DATA_W-1:0] wr_data,
  output evau_pkg::evau_local_t        vars
);
  evau_pkg::evau_local_t state_reg;
  evau_pkg::evau_local_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_en && wr_sel == `EVAU_SEL_A) begin
      state_next.var_a = wr_data;
    end
    if (wr_en && wr_sel == `EVAU_SEL_B) begin
      state_next.var_b = wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '{var_a: `EVAU_VAR_RST, var_b: `EVAU_VAR_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign vars = state_reg;
endmodule : evau_local_vars

// ==== sim/evau_arith_unit_properties.sv ====
// assertions for the engine variable arithmetic unit
`timescale 1ns/1ps
module evau_arith_unit_properties (
  input wire logic            core_clk,
  input wire logic            rst,
  input evau_pkg::evau_cmd_t  cmd,
  input evau_pkg::evau_rsp_t  rsp,
  input wire logic [7:0]      global_var,
  input wire logic [23:0]     local_a_flat,
  input wire logic [23:0]     local_b_flat
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic go;
  assign go = cmd.valid && cmd.op != 2'h0 && cmd.engine != 2'h3 && cmd.target != 2'h3;
  sequence s_go_c; go && cmd.target == 2'h2; endsequence
  property p_done; cmd.valid && cmd.op != 2'h0 |=> rsp.done; endproperty
  property p_quiet; !cmd.valid |=> !rsp.done && $stable(local_a_flat); endproperty
  property p_bad; cmd.valid && cmd.op != 2'h0 && cmd.target == 2'h3
    |=> rsp.bad_target && $stable(global_var); endproperty
  property p_add; s_go_c ##0 (cmd.op == 2'h1 && cmd.engine == 2'h0 && cmd.src1 == 2'h0
    && cmd.src2 == 2'h1) |=> global_var == $past(local_a_flat[7:0]) + $past(local_b_flat[7:0]);
  endproperty
  property p_subi; s_go_c ##0 cmd.op == 2'h2 |=> global_var == $past(global_var) - $past(cmd.imm);
  endproperty
  property p_subv; s_go_c ##0 (cmd.op == 2'h3 && cmd.src1 == 2'h2 && cmd.src2 == 2'h3)
    |=> global_var == $past(global_var) - $past(cmd.mapped); endproperty
  property p_res; s_go_c |=> rsp.result == global_var && !rsp.bad_target; endproperty
  property p_hold; !cmd.valid |=> $stable(global_var); endproperty
  a_done: assert property (p_done) else $error("no done after command");
  a_quiet: assert property (p_quiet) else $error("activity without command");
  a_bad: assert property (p_bad) else $error("bad target written");
  a_add: assert property (p_add) else $error("wrong sum");
  a_subi: assert property (p_subi) else $error("wrong immediate difference");
  a_subv: assert property (p_subv) else $error("wrong variable difference");
  a_res: assert property (p_res) else $error("result differs from target");
  a_hold: assert property (p_hold) else $error("shared variable moved");
endmodule : evau_arith_unit_properties
bind evau_arith_unit evau_arith_unit_properties evau_arith_unit_properties_i (.core_clk(core_clk),
  .rst(rst), .cmd(cmd), .rsp(rsp), .global_var(global_var), .local_a_flat(local_a_flat),
  .local_b_flat(local_b_flat));

// ==== sim/evau_seq_model.sv ====
// sequencer model issuing one command at a time
`timescale 1ns/1ps
module evau_seq_model (
  input wire logic            core_clk,
  output evau_pkg::evau_cmd_t cmd
);
  initial cmd = '0;
  task send(input evau_pkg::evau_cmd_t c);
    @(posedge core_clk) cmd <= c;
    @(posedge core_clk) begin
      cmd.valid  <= 1'h0;
      cmd.mapped <= ~c.mapped;
    end
  endtask : send
endmodule : evau_seq_model

// ==== sim/tb_evau_arith_unit.sv ====
// testbench for the engine variable arithmetic unit
`timescale 1ns/1ps
module tb_evau_arith_unit;
  logic core_clk, rst;
  int failures = 0, cmp_count = 0;
  evau_pkg::evau_cmd_t cmd;
  evau_pkg::evau_rsp_t rsp;
  logic [7:0]  global_var;
  logic [23:0] la, lb;
  evau_seq_model evau_seq_model_i (.core_clk(core_clk), .cmd(cmd));
  evau_arith_unit evau_arith_unit_i (.core_clk(core_clk), .rst(rst), .cmd(cmd), .rsp(rsp),
    .global_var(global_var), .local_a_flat(la), .local_b_flat(lb));
  task chk(input logic [23:0] g, e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task op(input logic [1:0] o, e, t, s1, s2, input logic [7:0] im, mp, ex);
    evau_seq_model_i.send('{1'h1, evau_pkg::evau_op_t'(o), e, t, s1, s2, im, mp});
    #1;
    chk(rsp.done, 1'h1);
    chk(rsp.bad_target, t == 2'h3 || e == 2'h3);
    if (t != 2'h3 && e != 2'h3) chk(rsp.result, ex);
  endtask : op
  task t_wrap;
    op(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 8'h01, 8'h00, 8'hFF);
    op(2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 8'hFE, 8'h00, 8'h02);
    op(2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 8'h00, 8'h00, 8'h01);
    chk(lb, 24'h000002);
  endtask : t_wrap
  task t_shared;
    op(2'h3, 2'h1, 2'h2, 2'h2, 2'h3, 8'h00, 8'h05, 8'hFC);
    op(2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 8'hFD, 8'h00, 8'hFF);
    op(2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 8'h00, 8'h00, 8'hFE);
    chk(la, 24'h00FEFF);
  endtask : t_shared
  task t_refuse;
    op(2'h3, 2'h0, 2'h3, 2'h0, 2'h1, 8'h00, 8'h00, 8'h00);
    op(2'h1, 2'h3, 2'h2, 2'h0, 2'h1, 8'h00, 8'h00, 8'h00);
    chk(global_var, 8'hFF);
  endtask : t_refuse
  task t_idle;
    op(2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 8'h01, 8'h00, 8'hFF);
    @(posedge core_clk);
    #1;
    chk(rsp.done, 1'h0);
    chk(rsp.result, 8'hFF);
    evau_seq_model_i.send('{1'h1, evau_pkg::EVAU_OP_NONE, 2'h0, 2'h2, 2'h0, 2'h1, 8'h00,
                            8'h00});
    #1;
    chk(rsp.done, 1'h0);
    chk(rsp.result, 8'hFF);
    chk(global_var, 8'hFF);
    chk(lb, 24'hFF0002);
  endtask : t_idle
  task t_reset;
    @(posedge core_clk) rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    chk(la, 24'h000000);
    chk(lb, 24'h000000);
    chk(global_var, 8'h00);
    chk(rsp, 10'h000);
    op(2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 8'h00, 8'h07, 8'h07);
  endtask : t_reset
  task finish_test;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    failures++;
    finish_test;
  end
  initial begin
    rst = 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    t_wrap;
    t_shared;
    t_refuse;
    t_idle;
    t_reset;
    finish_test;
  end
endmodule : tb_evau_arith_unit
